//--- ucbs_cell_queue.sv
`timescale 1ns/1ps
module ucbs_cell_queue
    import ucbs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_valid,
    input wire logic [15:0] wr_data,
    input wire logic [5:0] wr_chan,
    output logic wr_ready,
    output logic full,
    input wire logic [4:0] rd_idx,
    output logic [15:0] rd_data,
    output logic [5:0] rd_chan,
    input wire logic pop
);
    // ------------------------------------------------------------
    // One cell per link; a link stalls only itself
    // ------------------------------------------------------------
    logic [15:0] mem [CELL_WORDS];
    logic [15:0] next_mem [CELL_WORDS];
    logic [4:0] wr_cnt;
    logic [4:0] next_wr_cnt;
    logic [5:0] chan;
    logic [5:0] next_chan;
    logic is_full;
    logic next_is_full;
    // Ready is its own flop so the lane pin sees no gate after a register
    logic rdy;

    assign wr_ready = rdy;
    assign full = is_full;
    assign rd_data = mem[rd_idx];
    assign rd_chan = chan;

    always_comb begin
        next_mem = mem;
        next_wr_cnt = wr_cnt;
        next_chan = chan;
        next_is_full = is_full;
        if (pop) begin
            next_is_full = 1'b0;
        end
        if (wr_valid && !is_full) begin
            next_mem[wr_cnt] = wr_data;
            if (wr_cnt == 5'h00) begin
                next_chan = wr_chan;
            end
            if (wr_cnt == CELL_LAST_IDX) begin
                next_wr_cnt = 5'h00;
                next_is_full = 1'b1;
            end else begin
                next_wr_cnt = wr_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_cnt <= 5'h00;
            chan <= 6'h00;
            is_full <= 1'b0;
            rdy <= 1'b1;
        end else begin
            wr_cnt <= next_wr_cnt;
            chan <= next_chan;
            is_full <= next_is_full;
            rdy <= !next_is_full;
        end
        mem <= next_mem;
    end

endmodule

//--- ucbs_chk.sv
`timescale 1ns/1ps
module ucbs_chk (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic [7:0] SERIAL_RX_LANE_VALID,
    input wire logic [7:0] SERIAL_RX_LANE_READY,
    input wire logic UP_READ_ENABLE_N,
    input wire logic [4:0] UP_POLL_ADDRESS,
    input wire logic [4:0] DEVICE_BASE_ADDRESS_PINS,
    input wire logic [15:0] UP_CELL_DATA,
    input wire logic UP_WORD_PARITY,
    input wire logic UP_CELL_START_MARKER,
    input wire logic UP_TRANSFER_START_MARKER,
    input wire logic UP_BUS_OE,
    input wire logic UP_CELL_AVAILABLE_OE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // Even parity only; odd mode is not watched here
    a_word_parity: assert property (UP_BUS_OE |-> UP_WORD_PARITY == ^UP_CELL_DATA)
        else $error("parity does not match data word");
    a_addr_field: assert property (UP_BUS_OE && UP_TRANSFER_START_MARKER |->
        UP_CELL_DATA[15:9] == {2'b00, $past(DEVICE_BASE_ADDRESS_PINS, 4)})
        else $error("address word top bits wrong");
    a_ext_second_word: assert property (UP_BUS_OE && UP_TRANSFER_START_MARKER ##1 UP_BUS_OE
        |-> UP_CELL_START_MARKER)
        else $error("cell start not on second word");
    a_start_single: assert property (UP_BUS_OE && UP_CELL_START_MARKER
        |=> !(UP_BUS_OE && UP_CELL_START_MARKER))
        else $error("cell start held two words");
    a_poll_miss: assert property ((UP_POLL_ADDRESS != DEVICE_BASE_ADDRESS_PINS) [*5]
        |=> !UP_CELL_AVAILABLE_OE)
        else $error("cell available driven without match");
    a_poll_hit: assert property ((UP_POLL_ADDRESS == DEVICE_BASE_ADDRESS_PINS) [*5]
        |=> UP_CELL_AVAILABLE_OE)
        else $error("cell available not driven on match");
    a_release_idle: assert property (UP_READ_ENABLE_N [*5] |=> !UP_BUS_OE)
        else $error("bus driven while enable high");
    a_oe_cause: assert property ($rose(UP_BUS_OE) |->
        !$past(UP_READ_ENABLE_N, 3) || !$past(UP_READ_ENABLE_N, 4))
        else $error("bus driven without enable");
    a_lane_take: assert property ((~SERIAL_RX_LANE_READY & $past(SERIAL_RX_LANE_READY)
        & ~$past(SERIAL_RX_LANE_VALID)) == 8'h00)
        else $error("lane refused without a word");
    a_apb_answer: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("apb answer not one cycle after setup");
endmodule
bind ucbs_top ucbs_chk i_chk (.*);

//--- ucbs_pkg.sv
package ucbs_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int LINK_COUNT = 8;
    localparam int CELL_WORDS = 27;
    localparam int WORD_W = 16;
    localparam logic [4:0] CELL_LAST_IDX = 5'h1A;
    localparam logic [4:0] HDR_CHECK_IDX = 5'h02;
    localparam logic [5:0] CONTROL_CHAN_CODE = 6'h3E;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] WEIGHT_OFFSET = 8'h04;
    localparam logic [7:0] PREPEND_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    localparam int CTRL_EXT_MODE_BIT = 0;
    localparam int CTRL_ADDR_IN_HCHK_BIT = 1;
    localparam int CTRL_PREPEND_EN_BIT = 2;
    localparam int CTRL_ODD_PARITY_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] WEIGHT_RESET = 16'h0000;
    localparam logic [15:0] PREPEND_RESET = 16'h0000;
    localparam int STATUS_BUSY_BIT = 8;
    localparam int STATUS_LINK_LSB = 9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UCBS_IDLE = 2'b00,
        UCBS_XFER = 2'b01
    } ucbs_state_type;

    typedef struct packed {
        logic [15:0] data;
        logic parity;
        logic cell_start;
        logic xfer_start;
    } ucbs_bus_word_type;

endpackage

//--- ucbs_tm_model.sv
`timescale 1ns/1ps
module ucbs_tm_model (
    input wire logic clk,
    input wire logic sel,
    input wire logic poll_self,
    input wire logic [4:0] base,
    output logic enable_n,
    output logic [4:0] poll
);
    initial begin
        enable_n = 1'b1;
        poll = 5'h00;
    end
    // Poll follows poll_self, not sel, so a pause may leave the poll on another slave
    always @(posedge clk) begin
        enable_n <= !sel;
        poll <= poll_self ? base : ~base;
    end
endmodule

//--- ucbs_top.sv
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module ucbs_top
    import ucbs_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [7:0] SERIAL_RX_LANE_VALID,
    input wire logic [7:0][15:0] SERIAL_RX_LANE_DATA,
    input wire logic [7:0][5:0] SERIAL_RX_LANE_CHAN,
    output logic [7:0] SERIAL_RX_LANE_READY,
    input wire logic UP_READ_ENABLE_N,
    input wire logic [4:0] UP_POLL_ADDRESS,
    input wire logic [4:0] DEVICE_BASE_ADDRESS_PINS,
    output logic [15:0] UP_CELL_DATA,
    output logic UP_WORD_PARITY,
    output logic UP_CELL_START_MARKER,
    output logic UP_TRANSFER_START_MARKER,
    output logic UP_BUS_OE,
    output logic UP_CELL_AVAILABLE,
    output logic UP_CELL_AVAILABLE_OE
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic en_meta_n, en_sync_n, en_dly_n;
    logic [4:0] poll_meta, poll_sync;
    logic [4:0] base_meta, base_sync;
    logic match_dly;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            en_meta_n <= 1'b1;
            en_sync_n <= 1'b1;
            en_dly_n <= 1'b1;
            poll_meta <= 5'h00;
            poll_sync <= 5'h00;
            base_meta <= 5'h00;
            base_sync <= 5'h00;
            match_dly <= 1'b0;
        end else begin
            en_meta_n <= UP_READ_ENABLE_N;
            en_sync_n <= en_meta_n;
            en_dly_n <= en_sync_n;
            poll_meta <= UP_POLL_ADDRESS;
            poll_sync <= poll_meta;
            base_meta <= DEVICE_BASE_ADDRESS_PINS;
            base_sync <= base_meta;
            match_dly <= (poll_sync == base_sync);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0] ctrl, next_ctrl;
    logic [15:0] weight, next_weight;
    logic [15:0] prepend, next_prepend;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [7:0] q_full;
    ucbs_state_type state, next_state;
    logic [2:0] cur_link, next_cur_link;

    function automatic logic addr_known(input logic [7:0] a);
        return a == CTRL_OFFSET || a == WEIGHT_OFFSET || a == PREPEND_OFFSET
            || a == STATUS_OFFSET;
    endfunction

    always_comb begin
        next_ctrl = ctrl;
        next_weight = weight;
        next_prepend = prepend;
        next_prdata = PRDATA;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (PSEL && !PENABLE) begin
            next_pready = 1'b1;
            next_pslverr = !addr_known(PADDR);
            next_prdata = 32'h0000_0000;
            case (PADDR)
                CTRL_OFFSET: next_prdata[3:0] = ctrl;
                WEIGHT_OFFSET: next_prdata[15:0] = weight;
                PREPEND_OFFSET: next_prdata[15:0] = prepend;
                STATUS_OFFSET: begin
                    next_prdata[7:0] = q_full;
                    next_prdata[STATUS_BUSY_BIT] = (state == UCBS_XFER);
                    next_prdata[STATUS_LINK_LSB +: 3] = cur_link;
                end
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        if (PSEL && PENABLE && PREADY && PWRITE) begin
            case (PADDR)
                CTRL_OFFSET: next_ctrl = PWDATA[3:0];
                WEIGHT_OFFSET: next_weight = PWDATA[15:0];
                PREPEND_OFFSET: next_prepend = PWDATA[15:0];
                default: next_ctrl = ctrl;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ctrl <= CTRL_RESET;
            weight <= WEIGHT_RESET;
            prepend <= PREPEND_RESET;
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            weight <= next_weight;
            prepend <= next_prepend;
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Link queues
    // ------------------------------------------------------------
    logic [4:0] rd_idx;
    logic [7:0] pop;
    logic [15:0] q_data [LINK_COUNT];
    logic [5:0] q_chan [LINK_COUNT];

    for (genvar g = 0; g < LINK_COUNT; g++) begin : gen_queue
        ucbs_cell_queue u_queue (
            .clk(REF_CLK),
            .resetn(RESETN),
            .wr_valid(SERIAL_RX_LANE_VALID[g]),
            .wr_data(SERIAL_RX_LANE_DATA[g]),
            .wr_chan(SERIAL_RX_LANE_CHAN[g]),
            .wr_ready(SERIAL_RX_LANE_READY[g]),
            .full(q_full[g]),
            .rd_idx(rd_idx),
            .rd_data(q_data[g]),
            .rd_chan(q_chan[g]),
            .pop(pop[g])
        );
    end

    // ------------------------------------------------------------
    // Weighted round robin and transfer sequencer
    // ------------------------------------------------------------
    logic ext_mode, addr_in_hchk, prep_en;
    logic en_eff_n, match_eff, sel, next_sel;
    logic [2:0] credit, next_credit, rr_link, next_rr_link, pick, lk;
    logic [4:0] pos, next_pos, cur_pos, hdr_off, last_pos;
    logic [15:0] addr_word, word;
    ucbs_bus_word_type bus, next_bus;
    logic bus_oe, next_bus_oe, next_avail, next_avail_oe;

    function automatic logic [2:0] next_ready_link(input logic [2:0] from,
                                                   input logic [7:0] mask);
        logic [2:0] res;
        logic [2:0] cand;
        res = from;
        for (int i = 7; i >= 1; i--) begin
            cand = from + i[2:0];
            if (mask[cand]) begin
                res = cand;
            end
        end
        return res;
    endfunction

    // Extended mode reacts one edge later by using the delayed samples
    assign ext_mode = ctrl[CTRL_EXT_MODE_BIT];
    assign en_eff_n = ext_mode ? en_dly_n : en_sync_n;
    assign match_eff = ext_mode ? match_dly : (poll_sync == base_sync);
    assign addr_in_hchk = ctrl[CTRL_ADDR_IN_HCHK_BIT];
    assign prep_en = ctrl[CTRL_PREPEND_EN_BIT];
    // Word zero is dropped when the address rides in the check word
    assign hdr_off = {4'h0, !addr_in_hchk} + {4'h0, prep_en};
    assign last_pos = hdr_off + CELL_LAST_IDX;

    always_comb begin
        // Stay on this link while credit lasts, else next link holding a cell
        if (q_full[rr_link] && credit <= weight[2 * rr_link +: 2]) begin
            pick = rr_link;
        end else begin
            pick = next_ready_link(rr_link, q_full);
        end
        lk = (state == UCBS_IDLE) ? pick : cur_link;
        cur_pos = (state == UCBS_IDLE) ? 5'h00 : pos;
        rd_idx = cur_pos - hdr_off;
        addr_word = {2'b00, base_sync, lk, q_chan[lk]};
        if (cur_pos < hdr_off) begin
            word = (cur_pos == 5'h00 && !addr_in_hchk) ? addr_word : prepend;
        end else if (addr_in_hchk && rd_idx == HDR_CHECK_IDX) begin
            word = addr_word;
        end else begin
            word = q_data[lk];
        end
    end

    always_comb begin
        next_state = state;
        next_pos = pos;
        next_cur_link = cur_link;
        next_rr_link = rr_link;
        next_credit = credit;
        next_sel = sel;
        next_bus = bus;
        next_bus_oe = 1'b0;
        pop = 8'h00;
        if (!en_eff_n) begin
            next_bus.data = word;
            next_bus.parity = (^word) ^ ctrl[CTRL_ODD_PARITY_BIT];
            next_bus.cell_start = ext_mode ? (cur_pos == 5'h01) : (cur_pos == 5'h00);
            next_bus.xfer_start = ext_mode && (cur_pos == 5'h00);
        end
        if (en_eff_n) begin
            // Selection uses the poll address of the last high cycle
            next_sel = match_eff;
        end else if (state == UCBS_XFER && (sel || ext_mode)) begin
            next_bus_oe = 1'b1;
            next_pos = pos + 5'h01;
            if (pos == last_pos) begin
                pop[cur_link] = 1'b1;
                next_state = UCBS_IDLE;
                next_sel = !ext_mode && sel;
            end
        end else if (state == UCBS_IDLE && sel && q_full != 8'h00) begin
            next_bus_oe = 1'b1;
            next_state = UCBS_XFER;
            next_cur_link = pick;
            next_pos = 5'h01;
            next_rr_link = pick;
            next_credit = (pick == rr_link) ? credit + 3'h1 : 3'h1;
        end
        next_avail = q_full != 8'h00;
        next_avail_oe = match_eff;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            state <= UCBS_IDLE;
            pos <= 5'h00;
            cur_link <= 3'h0;
            rr_link <= 3'h0;
            credit <= 3'h1;
            sel <= 1'b0;
            bus <= '0;
            bus_oe <= 1'b0;
            UP_CELL_AVAILABLE <= 1'b0;
            UP_CELL_AVAILABLE_OE <= 1'b0;
        end else begin
            state <= next_state;
            pos <= next_pos;
            cur_link <= next_cur_link;
            rr_link <= next_rr_link;
            credit <= next_credit;
            sel <= next_sel;
            bus <= next_bus;
            bus_oe <= next_bus_oe;
            UP_CELL_AVAILABLE <= next_avail;
            UP_CELL_AVAILABLE_OE <= next_avail_oe;
        end
    end

    // Outputs are flops of the bus struct; the oe flop qualifies them
    assign UP_CELL_DATA = bus.data;
    assign UP_WORD_PARITY = bus.parity;
    assign UP_CELL_START_MARKER = bus.cell_start;
    assign UP_TRANSFER_START_MARKER = bus.xfer_start;
    assign UP_BUS_OE = bus_oe;

endmodule

//--- ucbs_top_tb_top.sv
`timescale 1ns/1ps
module ucbs_top_tb_top
    import ucbs_pkg::*;
;
    logic REF_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, UP_READ_ENABLE_N, UP_WORD_PARITY, UP_CELL_START_MARKER;
    logic UP_TRANSFER_START_MARKER, UP_BUS_OE, UP_CELL_AVAILABLE, UP_CELL_AVAILABLE_OE;
    logic [7:0] SERIAL_RX_LANE_VALID = 8'h00;
    logic [7:0][15:0] SERIAL_RX_LANE_DATA = '0;
    logic [7:0][5:0] SERIAL_RX_LANE_CHAN = '0;
    logic [7:0] SERIAL_RX_LANE_READY;
    logic [4:0] UP_POLL_ADDRESS;
    logic [4:0] DEVICE_BASE_ADDRESS_PINS = 5'h15;
    logic [15:0] UP_CELL_DATA;
    logic sel = 1'b0;
    logic self = 1'b0;
    logic [31:0] r;
    logic e;
    ucbs_bus_word_type rx[$];
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    ucbs_top i_dut (.*);
    ucbs_tm_model i_tm (.clk(REF_CLK), .sel(sel), .poll_self(self),
        .base(DEVICE_BASE_ADDRESS_PINS), .enable_n(UP_READ_ENABLE_N), .poll(UP_POLL_ADDRESS));
    always #4 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        if (UP_BUS_OE === 1'b1)
            rx.push_back({UP_CELL_DATA, UP_WORD_PARITY, UP_CELL_START_MARKER,
                UP_TRANSFER_START_MARKER});
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        tick(1);
        PENABLE <= 1'b1;
        tick(1);
        while (PREADY !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(n < 20, "apb no ready");
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        tick(1);
    endtask
    function automatic logic [15:0] wd(input int l, input int w);
        return 16'(l * 4096 + w * 17);
    endfunction
    task automatic send_cell(input int l, input logic [5:0] ch);
        int w, n;
        w = 0;
        n = 0;
        SERIAL_RX_LANE_CHAN[l] <= ch;
        while (w < CELL_WORDS && n < 200) begin
            SERIAL_RX_LANE_VALID[l] <= 1'b1;
            SERIAL_RX_LANE_DATA[l] <= wd(l, w);
            tick(1);
            if (SERIAL_RX_LANE_READY[l] === 1'b1)
                w++;
            n++;
        end
        chk(w == CELL_WORDS, "lane words taken");
        SERIAL_RX_LANE_VALID[l] <= 1'b0;
        SERIAL_RX_LANE_DATA[l] <= ~wd(l, w - 1);
        SERIAL_RX_LANE_CHAN[l] <= ~ch;
    endtask
    task automatic chk_cell(input int k, input logic x, input int l, input logic [5:0] ch);
        ucbs_bus_word_type v;
        for (int i = 0; i < 28; i++) begin
            v = rx[k + i];
            chk(v.data === (i == 0 ? {2'b00, DEVICE_BASE_ADDRESS_PINS, 3'(l), ch}
                : wd(l, i - 1)), "cell word");
            chk(v.parity === ^v.data, "parity");
            chk(v.cell_start === (i == (x ? 1 : 0)), "cell start");
            chk(v.xfer_start === (x && i == 0), "transfer start");
        end
    endtask
    task automatic pair(input logic x, input int la, input int ca, input int lb, input int cb);
        int n;
        n = 0;
        while (rx.size() < 56 && n < 500) begin
            tick(1);
            n++;
        end
        chk(rx.size() == 56, "word count");
        if (rx.size() == 56 && rx[0].data[8:6] === 3'(lb)) begin
            chk_cell(0, x, lb, 6'(cb));
            chk_cell(28, x, la, 6'(ca));
        end else if (rx.size() == 56) begin
            chk_cell(0, x, la, 6'(ca));
            chk_cell(28, x, lb, 6'(cb));
        end
    endtask
    task automatic t_regs();
        chk(SERIAL_RX_LANE_READY === 8'hFF && PREADY === 1'b0, "reset outputs");
        apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
        chk(r === 32'h0000_0000 && e === 1'b0, "ctrl reset");
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(r === 32'h0000_0000 && e === 1'b1, "unmapped access");
    endtask
    task automatic t_legacy();
        tick(8);
        chk(UP_CELL_AVAILABLE_OE === 1'b0, "poll miss");
        self <= 1'b1;
        tick(8);
        chk(UP_CELL_AVAILABLE_OE === 1'b1 && UP_CELL_AVAILABLE === 1'b0, "poll empty");
        send_cell(3, 6'h05);
        send_cell(6, CONTROL_CHAN_CODE);
        tick(8);
        chk(UP_CELL_AVAILABLE === 1'b1, "poll full");
        rx.delete();
        sel <= 1'b1;
        pair(1'b0, 3, 5, 6, 62);
        tick(20);
        chk(rx.size() == 56, "no extra words");
        sel <= 1'b0;
        tick(8);
    endtask
    task automatic t_ext();
        apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
        send_cell(1, 6'h09);
        send_cell(2, 6'h21);
        rx.delete();
        sel <= 1'b1;
        tick(80);
        chk(rx.size() == 28, "deselect after cell");
        sel <= 1'b0;
        tick(6);
        sel <= 1'b1;
        tick(12);
        // Pause with the poll elsewhere; extended must resume anyway
        self <= 1'b0;
        sel <= 1'b0;
        tick(4);
        self <= 1'b1;
        sel <= 1'b1;
        pair(1'b1, 1, 9, 2, 33);
        sel <= 1'b0;
        tick(8);
    endtask
    task automatic t_wrr();
        logic [2:0] lk;
        apb(1'b1, WEIGHT_OFFSET, 32'h0000_0300);
        send_cell(5, 6'h01);
        for (int k = 0; k < 6; k++) begin
            if (k < 5 && SERIAL_RX_LANE_READY[4] === 1'b1)
                send_cell(4, 6'h02);
            if (k < 5 && SERIAL_RX_LANE_READY[5] === 1'b1)
                send_cell(5, 6'h01);
            rx.delete();
            sel <= 1'b1;
            tick(40);
            sel <= 1'b0;
            tick(6);
            lk = (k == 4) ? 3'h5 : 3'h4;
            chk(rx.size() == 28 && rx[0].data[8:6] === lk, "wrr order");
        end
    endtask
    task automatic t_opts();
        apb(1'b1, PREPEND_OFFSET, 32'h0000_A5C3);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0006);
        send_cell(7, 6'h11);
        rx.delete();
        sel <= 1'b1;
        tick(12);
        sel <= 1'b0;
        tick(4);
        sel <= 1'b1;
        tick(40);
        chk(rx.size() == 28, "legacy pause resume");
        for (int i = 0; i < 28; i++) begin
            chk(rx[i].data === (i == 0 ? 16'hA5C3 : (i == 3 ? {2'b00, DEVICE_BASE_ADDRESS_PINS,
                3'h7, 6'h11} : wd(7, i - 1))), "option word");
            chk(rx[i].cell_start === (i == 0), "option start");
            chk(rx[i].xfer_start === 1'b0, "option xfer");
            chk(rx[i].parity === ^rx[i].data, "option parity");
        end
        sel <= 1'b0;
        tick(8);
    endtask
    initial begin
        tick(6);
        RESETN <= 1'b1;
        tick(3);
        t_regs();
        t_legacy();
        t_ext();
        t_wrr();
        t_opts();
        end_sim();
    end
endmodule
